// [design/flpe_defs.svh]
`ifndef FLPE_DEFS_SVH
`define FLPE_DEFS_SVH

// ----------------------------------------------------------------------
// Flash geometry and key codes
// ----------------------------------------------------------------------
`define FLPE_ADDR_W       10
`define FLPE_PAGE_W       9
`define FLPE_PAGE_LAST    9'h1ff
`define FLPE_ERASED       8'hff
`define FLPE_KEY_FIRST    8'ha5
`define FLPE_KEY_SECOND   8'hf1

// ----------------------------------------------------------------------
// Register byte offsets and field positions
// ----------------------------------------------------------------------
`define FLPE_OFS_CTRL     4'h0
`define FLPE_OFS_KEY      4'h4
`define FLPE_OFS_STATUS   4'h8
`define FLPE_OFS_MASK     4'hc
`define FLPE_CTRL_WEN     0
`define FLPE_CTRL_EEN     1
`define FLPE_CTRL_BUSY    8
`define FLPE_KEYST_OPEN   0
`define FLPE_KEYST_DEAD   1
`define FLPE_ST_DONE      0
`define FLPE_ST_KEYF      1
`define FLPE_ST_FERR      2
`define FLPE_ST_W         3
`define FLPE_CTRL_RST     2'h0

// ----------------------------------------------------------------------
// Timing: ref_clk rate, program and erase times
// ----------------------------------------------------------------------
`define FLPE_CLK_MHZ      10
`define FLPE_PROG_TIME_US 20
`define FLPE_PROG_CYC     (`FLPE_PROG_TIME_US * `FLPE_CLK_MHZ)
`define FLPE_ERASE_TIME_US 10000
`define FLPE_ERASE_CYC    (`FLPE_ERASE_TIME_US * `FLPE_CLK_MHZ)
`define FLPE_TMR_W        18

`endif

// [design/flpe_pkg.sv]
package flpe_pkg;
	// Key lock progress
	typedef enum logic [2:0] {
		KEY_LOCKED,
		KEY_HALF,
		KEY_OPEN,
		KEY_USED,
		KEY_DEAD
	} flpe_key_e;

	// Array sequencer
	typedef enum logic [1:0] {
		ARR_IDLE,
		ARR_WAIT,
		ARR_PROG,
		ARR_ERASE
	} flpe_arr_e;
endpackage : flpe_pkg

// [design/flpe_op_if.sv]
`include "flpe_defs.svh"

interface flpe_op_if;
	logic                     start;
	logic                     erase;
	logic [`FLPE_ADDR_W-1:0]  addr;
	logic [7:0]               wdata;
	logic                     busy;
	logic                     done;

	modport ctrl (output start, erase, addr, wdata, input busy, done);
	modport arr  (input start, erase, addr, wdata, output busy, done);
endinterface : flpe_op_if

// [design/flpe_key.sv]
`include "flpe_defs.svh"

module flpe_key (
	// Clock and reset
	input  wire logic                ref_clk,
	input  wire logic                rst_n,
	// Key register writes and flash attempts
	input  wire logic                key_wr,
	input  wire logic [7:0]          key_val,
	input  wire logic                attempt,
	input  wire logic                op_done,
	// Lock state
	output flpe_pkg::flpe_key_e      key_st
);
	flpe_pkg::flpe_key_e st_q, st_d;

	// ------------------------------------------------------------------
	// Key sequence
	// ------------------------------------------------------------------
	// Only a reset leaves the dead state
	always_comb begin
		st_d = st_q;
		case (st_q)
			flpe_pkg::KEY_LOCKED: begin
				if (attempt)
					st_d = flpe_pkg::KEY_DEAD;
				else if (key_wr)
					st_d = (key_val == `FLPE_KEY_FIRST) ?
						flpe_pkg::KEY_HALF : flpe_pkg::KEY_DEAD;
			end
			flpe_pkg::KEY_HALF: begin
				if (attempt)
					st_d = flpe_pkg::KEY_DEAD;
				else if (key_wr)
					st_d = (key_val == `FLPE_KEY_SECOND) ?
						flpe_pkg::KEY_OPEN : flpe_pkg::KEY_DEAD;
			end
			flpe_pkg::KEY_OPEN: begin
				if (attempt)
					st_d = flpe_pkg::KEY_USED;
				else if (key_wr)
					st_d = flpe_pkg::KEY_DEAD;
			end
			flpe_pkg::KEY_USED: begin
				if (key_wr || attempt)
					st_d = flpe_pkg::KEY_DEAD;
				else if (op_done)
					st_d = flpe_pkg::KEY_LOCKED;
			end
			flpe_pkg::KEY_DEAD: st_d = flpe_pkg::KEY_DEAD;
			default:            st_d = flpe_pkg::KEY_DEAD;
		endcase
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n)
			st_q <= flpe_pkg::KEY_LOCKED;
		else
			st_q <= st_d;
	end

	assign key_st = st_q;

	// ------------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------------
	sequence s_first_key;
		key_wr && !attempt && key_val == `FLPE_KEY_FIRST;
	endsequence

	sequence s_second_key;
		key_wr && !attempt && key_val == `FLPE_KEY_SECOND;
	endsequence

	property p_key_pair;
		@(posedge ref_clk) disable iff (!rst_n)
		st_q == flpe_pkg::KEY_HALF ##0 s_second_key
		|=> st_q == flpe_pkg::KEY_OPEN;
	endproperty
	a_key_pair: assert property (p_key_pair)
		else $error("key pair did not unlock");

	property p_key_half;
		@(posedge ref_clk) disable iff (!rst_n)
		st_q == flpe_pkg::KEY_LOCKED ##0 s_first_key
		|=> st_q == flpe_pkg::KEY_HALF;
	endproperty
	a_key_half: assert property (p_key_half)
		else $error("first key did not advance the lock");

	// A quiet gap of any length must keep the first key
	property p_key_gap;
		@(posedge ref_clk) disable iff (!rst_n)
		st_q == flpe_pkg::KEY_HALF && !key_wr && !attempt
		|=> st_q == flpe_pkg::KEY_HALF;
	endproperty
	a_key_gap: assert property (p_key_gap)
		else $error("key lock lost the first key in a gap");

	property p_dead_sticks;
		@(posedge ref_clk) disable iff (!rst_n)
		st_q == flpe_pkg::KEY_DEAD |=> st_q == flpe_pkg::KEY_DEAD;
	endproperty
	a_dead_sticks: assert property (p_dead_sticks)
		else $error("key lock left the dead state");
endmodule : flpe_key

// [design/flpe_array.sv]
`include "flpe_defs.svh"

module flpe_array #(
	parameter int unsigned ERASE_CYC = `FLPE_ERASE_CYC
) (
	// Clock and reset
	input  wire logic                    ref_clk,
	input  wire logic                    rst_n,
	// Operation requests
	flpe_op_if.arr                       op,
	// Code read port
	input  wire logic [`FLPE_ADDR_W-1:0] rd_addr,
	output logic      [7:0]              rd_data
);
	localparam logic [`FLPE_TMR_W-1:0] PROG_LAST =
		`FLPE_TMR_W'(`FLPE_PROG_CYC - 1);
	localparam logic [`FLPE_TMR_W-1:0] ERASE_LAST =
		`FLPE_TMR_W'(ERASE_CYC - 1);

	logic [7:0] mem [0:(1 << `FLPE_ADDR_W)-1];

	flpe_pkg::flpe_arr_e        st_q;
	logic [`FLPE_TMR_W-1:0]     cnt_q;
	logic [`FLPE_ADDR_W-1:0]    addr_q;
	logic [7:0]                 data_q;
	logic                       erase_q;
	logic [`FLPE_PAGE_W-1:0]    ptr_q;
	logic                       done_q;
	logic [7:0]                 rd_q;

	// ------------------------------------------------------------------
	// Array write port
	// ------------------------------------------------------------------
	// A program can only clear bits: old value and new value are ANDed
	wire                    mem_we = (st_q == flpe_pkg::ARR_PROG) ||
		(st_q == flpe_pkg::ARR_ERASE);
	wire [`FLPE_ADDR_W-1:0] mem_wa = (st_q == flpe_pkg::ARR_ERASE) ?
		{addr_q[`FLPE_ADDR_W-1:`FLPE_PAGE_W], ptr_q} : addr_q;
	wire [7:0]              mem_wd = (st_q == flpe_pkg::ARR_ERASE) ?
		`FLPE_ERASED : (mem[addr_q] & data_q);
	wire                    last_byte = (ptr_q == `FLPE_PAGE_LAST);

	// ------------------------------------------------------------------
	// Sequencer: self-timed, no polling needed
	// ------------------------------------------------------------------
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			st_q    <= flpe_pkg::ARR_IDLE;
			cnt_q   <= '0;
			addr_q  <= '0;
			data_q  <= 8'h00;
			erase_q <= 1'b0;
			ptr_q   <= '0;
			done_q  <= 1'b0;
		end else begin
			done_q <= 1'b0;
			case (st_q)
				flpe_pkg::ARR_IDLE: if (op.start) begin
					st_q    <= flpe_pkg::ARR_WAIT;
					addr_q  <= op.addr;
					data_q  <= op.wdata;
					erase_q <= op.erase;
					cnt_q   <= op.erase ? ERASE_LAST : PROG_LAST;
				end
				flpe_pkg::ARR_WAIT: begin
					cnt_q <= cnt_q - 1'b1;
					ptr_q <= '0;
					if (cnt_q == '0)
						st_q <= erase_q ? flpe_pkg::ARR_ERASE :
							flpe_pkg::ARR_PROG;
				end
				flpe_pkg::ARR_PROG: begin
					st_q   <= flpe_pkg::ARR_IDLE;
					done_q <= 1'b1;
				end
				flpe_pkg::ARR_ERASE: begin
					ptr_q <= ptr_q + 1'b1;
					if (last_byte) begin
						st_q   <= flpe_pkg::ARR_IDLE;
						done_q <= 1'b1;
					end
				end
				default: st_q <= flpe_pkg::ARR_IDLE;
			endcase
		end
	end

	// Storage has no reset: it is non-volatile
	always_ff @(posedge ref_clk) begin
		if (mem_we)
			mem[mem_wa] <= mem_wd;
		rd_q <= mem[rd_addr];
	end

	assign op.busy = (st_q != flpe_pkg::ARR_IDLE);
	assign op.done = done_q;
	assign rd_data = rd_q;

	// ------------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------------
	property p_prog_time;
		@(posedge ref_clk) disable iff (!rst_n)
		op.start && !op.erase && !op.busy |-> ##202 done_q;
	endproperty
	a_prog_time: assert property (p_prog_time)
		else $error("byte program did not finish on time");

	property p_erase_fill;
		@(posedge ref_clk) disable iff (!rst_n)
		st_q == flpe_pkg::ARR_ERASE |-> mem_we &&
			mem_wd == `FLPE_ERASED &&
			mem_wa[`FLPE_ADDR_W-1:`FLPE_PAGE_W] ==
			addr_q[`FLPE_ADDR_W-1:`FLPE_PAGE_W];
	endproperty
	a_erase_fill: assert property (p_erase_fill)
		else $error("erase wrote outside page or not erased value");
endmodule : flpe_array

// [design/flpe_top.sv]
//Contract
// - Byte write only clears bits to zero
// - Erase sets whole 512-byte page to 0xFF
// - Write and erase are self-timed
// - Core stalls while operation runs
// - Write enable routes data-move writes to flash
// - Write enable stays set until software clears
// - Keys 0xA5 then 0xF1, any gap
// - Wrong or misordered key locks until reset
// - Attempt before keys also locks until reset
// - Lock re-arms after every operation; debug-port operations leave it as it was
// - Erase enable plus write erases page
// - Plain write programs one addressed byte
// - Flash write with supply monitor off forces error reset
// - Data-move reads always go to RAM
// - Debug port programs flash, only path blank
`include "flpe_defs.svh"

module flpe_top #(
	parameter int unsigned ERASE_CYC = `FLPE_ERASE_CYC
) (
	// Clock and reset
	input  wire logic                    ref_clk,
	input  wire logic                    rst_n,
	// Avalon-MM register slave
	input  wire logic [3:0]              avs_address,
	input  wire logic                    avs_read,
	input  wire logic                    avs_write,
	input  wire logic [31:0]             avs_writedata,
	output logic      [31:0]             avs_readdata,
	output logic                         avs_waitrequest,
	// Core data-move and code-move accesses
	input  wire logic                    xdm_wr,
	input  wire logic                    xdm_rd,
	input  wire logic [15:0]             xdm_addr,
	input  wire logic [7:0]              xdm_wdata,
	input  wire logic                    cm_rd,
	input  wire logic [`FLPE_ADDR_W-1:0] cm_addr,
	output logic      [7:0]              cm_rdata,
	output logic                         core_stall,
	// External data RAM
	output logic                         external_data_ram_we,
	output logic                         external_data_ram_re,
	output logic      [15:0]             external_data_ram_addr,
	output logic      [7:0]              external_data_ram_wdata,
	// Two-wire debug port programming
	input  wire logic                    dbg_req,
	input  wire logic                    dbg_erase,
	input  wire logic [`FLPE_ADDR_W-1:0] dbg_addr,
	input  wire logic [7:0]              dbg_wdata,
	// Supply monitor and blank-array indication, asynchronous
	input  wire logic                    vdd_mon_on,
	input  wire logic                    vdd_mon_rst_on,
	input  wire logic                    flash_blank,
	// System outputs
	output logic                         flash_err_rst,
	output logic                         irq
);
	flpe_op_if op ();

	flpe_pkg::flpe_key_e        key_st;
	logic [1:0]                 ctrl_q;
	logic [`FLPE_ST_W-1:0]      stat_q;
	logic [`FLPE_ST_W-1:0]      mask_q;
	logic                       wait_q;
	logic [31:0]                rdat_q;
	logic [2:0]                 sync1_q;
	logic [2:0]                 sync2_q;
	logic                       fw_op_q;
	logic                       dead_q;
	logic                       ferr_q;
	logic                       irq_q;
	logic                       stall_q;
	logic                       xwe_q;
	logic                       xre_q;
	logic [15:0]                xaddr_q;
	logic [7:0]                 xdata_q;

	// ------------------------------------------------------------------
	// Input synchronisers
	// ------------------------------------------------------------------
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			sync1_q <= 3'h0;
			sync2_q <= 3'h0;
		end else begin
			sync1_q <= {flash_blank, vdd_mon_rst_on, vdd_mon_on};
			sync2_q <= sync1_q;
		end
	end

	// ------------------------------------------------------------------
	// Bus decode
	// ------------------------------------------------------------------
	// Every access gets exactly one wait cycle
	wire bus_go  = (avs_read || avs_write) && wait_q;
	wire wr_ctrl = bus_go && avs_write && avs_address == `FLPE_OFS_CTRL;
	wire wr_key  = bus_go && avs_write && avs_address == `FLPE_OFS_KEY;
	wire wr_stat = bus_go && avs_write &&
		avs_address == `FLPE_OFS_STATUS;
	wire wr_mask = bus_go && avs_write && avs_address == `FLPE_OFS_MASK;

	// ------------------------------------------------------------------
	// Flash request steering
	// ------------------------------------------------------------------
	wire wen      = ctrl_q[`FLPE_CTRL_WEN];
	wire een      = ctrl_q[`FLPE_CTRL_EEN];
	wire mon_ok   = sync2_q[0] && sync2_q[1];
	wire blank    = sync2_q[2];
	wire fl_wr    = xdm_wr && wen;
	wire ferr_go  = fl_wr && !mon_ok;
	// A blank array ignores firmware attempts, but a write with the monitor off still forces error reset
	wire attempt  = fl_wr && mon_ok && !blank;
	wire key_open = (key_st == flpe_pkg::KEY_OPEN);
	wire key_dead = (key_st == flpe_pkg::KEY_DEAD);
	wire fw_go    = attempt && key_open && !op.busy;
	wire dbg_go   = dbg_req && !op.busy && !fw_go;
	wire fw_done  = op.done && fw_op_q;

	assign op.start = fw_go || dbg_go;
	assign op.erase = fw_go ? een : dbg_erase;
	assign op.addr  = fw_go ? xdm_addr[`FLPE_ADDR_W-1:0] : dbg_addr;
	assign op.wdata = fw_go ? xdm_wdata : dbg_wdata;

	wire [`FLPE_ST_W-1:0] st_set = {ferr_go, key_dead && !dead_q, fw_done};
	wire [`FLPE_ST_W-1:0] st_clr = wr_stat ?
		avs_writedata[`FLPE_ST_W-1:0] : '0;

	// ------------------------------------------------------------------
	// Read mux
	// ------------------------------------------------------------------
	function automatic logic [31:0] rd_mux(input logic [3:0] a);
		logic [31:0] r;
		r = 32'h0000_0000;
		case (a)
			`FLPE_OFS_CTRL: begin
				r[1:0]             = ctrl_q;
				r[`FLPE_CTRL_BUSY] = op.busy;
			end
			`FLPE_OFS_KEY: begin
				r[`FLPE_KEYST_OPEN] = key_open;
				r[`FLPE_KEYST_DEAD] = key_dead;
			end
			`FLPE_OFS_STATUS: r[`FLPE_ST_W-1:0] = stat_q;
			`FLPE_OFS_MASK:   r[`FLPE_ST_W-1:0] = mask_q;
			default:          r = 32'h0000_0000;
		endcase
		return r;
	endfunction : rd_mux

	// ------------------------------------------------------------------
	// Register slave
	// ------------------------------------------------------------------
	// Enables change only by software writes, never by operations
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			wait_q <= 1'b1;
			rdat_q <= 32'h0000_0000;
			ctrl_q <= `FLPE_CTRL_RST;
			mask_q <= '0;
		end else begin
			wait_q <= !bus_go;
			if (bus_go && avs_read)
				rdat_q <= rd_mux(avs_address);
			if (wr_ctrl)
				ctrl_q <= avs_writedata[1:0];
			if (wr_mask)
				mask_q <= avs_writedata[`FLPE_ST_W-1:0];
		end
	end

	// Sticky events: a set in the clearing cycle survives
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			stat_q <= '0;
			dead_q <= 1'b0;
			irq_q  <= 1'b0;
		end else begin
			stat_q <= (stat_q & ~st_clr) | st_set;
			dead_q <= key_dead;
			irq_q  <= |(((stat_q & ~st_clr) | st_set) & mask_q);
		end
	end

	// ------------------------------------------------------------------
	// Core side: stall, error reset, RAM routing
	// ------------------------------------------------------------------
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			fw_op_q <= 1'b0;
			stall_q <= 1'b0;
			ferr_q  <= 1'b0;
			xwe_q   <= 1'b0;
			xre_q   <= 1'b0;
			xaddr_q <= 16'h0000;
			xdata_q <= 8'h00;
		end else begin
			if (op.start)
				fw_op_q <= fw_go;
			stall_q <= op.start || op.busy;
			ferr_q  <= ferr_go;
			xwe_q   <= xdm_wr && !wen;
			xre_q   <= xdm_rd;
			if (xdm_wr || xdm_rd) begin
				xaddr_q <= xdm_addr;
				xdata_q <= xdm_wdata;
			end
		end
	end

	// ------------------------------------------------------------------
	// Submodules
	// ------------------------------------------------------------------
	flpe_key u_key (
		.ref_clk (ref_clk),
		.rst_n   (rst_n),
		.key_wr  (wr_key),
		.key_val (avs_writedata[7:0]),
		.attempt (attempt),
		.op_done (fw_done),
		.key_st  (key_st)
	);

	flpe_array #(
		.ERASE_CYC (ERASE_CYC)
	) u_array (
		.ref_clk (ref_clk),
		.rst_n   (rst_n),
		.op      (op.arr),
		.rd_addr (cm_addr),
		.rd_data (cm_rdata)
	);

	assign avs_readdata    = rdat_q;
	assign avs_waitrequest = wait_q;
	assign core_stall      = stall_q;
	assign flash_err_rst   = ferr_q;
	assign irq             = irq_q;
	assign external_data_ram_we         = xwe_q;
	assign external_data_ram_re         = xre_q;
	assign external_data_ram_addr       = xaddr_q;
	assign external_data_ram_wdata      = xdata_q;

	// ------------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------------
	property p_route_flash;
		@(posedge ref_clk) disable iff (!rst_n)
		fw_go |=> op.busy && !external_data_ram_we;
	endproperty
	a_route_flash: assert property (p_route_flash)
		else $error("enabled write did not start a flash operation");

	property p_ram_write;
		@(posedge ref_clk) disable iff (!rst_n)
		xdm_wr && !wen && !wr_key |=> external_data_ram_we && $stable(key_st);
	endproperty
	a_ram_write: assert property (p_ram_write)
		else $error("disabled write missed RAM or moved key state");

	property p_ram_read;
		@(posedge ref_clk) disable iff (!rst_n)
		xdm_rd |=> external_data_ram_re && external_data_ram_addr == $past(xdm_addr);
	endproperty
	a_ram_read: assert property (p_ram_read)
		else $error("data-move read did not reach RAM");

	property p_err_reset;
		@(posedge ref_clk) disable iff (!rst_n)
		ferr_go && !op.busy |=> flash_err_rst && !op.busy;
	endproperty
	a_err_reset: assert property (p_err_reset)
		else $error("monitor off did not force error reset");

	property p_early_try;
		@(posedge ref_clk) disable iff (!rst_n)
		attempt && !key_open && key_st != flpe_pkg::KEY_USED
		|=> key_st == flpe_pkg::KEY_DEAD ##1 stat_q[`FLPE_ST_KEYF];
	endproperty
	a_early_try: assert property (p_early_try)
		else $error("early flash attempt did not lock keys");

	property p_relock;
		@(posedge ref_clk) disable iff (!rst_n)
		fw_done && !wr_key && !attempt |=> key_st == flpe_pkg::KEY_LOCKED;
	endproperty
	a_relock: assert property (p_relock)
		else $error("lock not re-armed after operation");

	property p_stall;
		@(posedge ref_clk) disable iff (!rst_n)
		op.start |=> core_stall throughout op.busy[*1];
	endproperty
	a_stall: assert property (p_stall)
		else $error("core not stalled during operation");

	property p_wen_kept;
		@(posedge ref_clk) disable iff (!rst_n)
		op.done && wen && !wr_ctrl |=> wen;
	endproperty
	a_wen_kept: assert property (p_wen_kept)
		else $error("write enable dropped after operation");
endmodule : flpe_top

// [test/flpe_core_model.sv]
`include "flpe_defs.svh"

module flpe_core_model (
	// Clock, stall and code read data
	input  wire logic                    ref_clk,
	input  wire logic                    core_stall,
	input  wire logic [7:0]              cm_rdata,
	// Data-move and code-move requests
	output logic                         xdm_wr,
	output logic                         xdm_rd,
	output logic      [15:0]             xdm_addr,
	output logic      [7:0]              xdm_wdata,
	output logic                         cm_rd,
	output logic      [`FLPE_ADDR_W-1:0] cm_addr
);
	timeunit 1ns;
	timeprecision 1ns;

	// Idle core
	initial begin
		xdm_wr = 1'b0;
		xdm_rd = 1'b0;
		xdm_addr = 16'h0;
		xdm_wdata = 8'h0;
		cm_rd = 1'b0;
		cm_addr = '0;
	end

	// One data-move pulse; a stalled core issues nothing
	task mv(input logic w, input logic [15:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		while (core_stall !== 1'b0) @(posedge ref_clk);
		xdm_wr <= w;
		xdm_rd <= !w;
		xdm_addr <= a;
		xdm_wdata <= d;
		@(posedge ref_clk);
		xdm_wr <= 1'b0;
		xdm_rd <= 1'b0;
		// Released operands must not keep looking valid
		xdm_addr <= ~a;
		xdm_wdata <= ~d;
	endtask : mv

	// Code-move read, data one edge after the address
	task cread(input logic [`FLPE_ADDR_W-1:0] a, output logic [7:0] d);
		@(posedge ref_clk);
		cm_rd <= 1'b1;
		cm_addr <= a;
		@(posedge ref_clk);
		cm_rd <= 1'b0;
		@(posedge ref_clk);
		d = cm_rdata;
		cm_addr <= ~a;
	endtask : cread
endmodule : flpe_core_model

// [test/tb.sv]
`include "flpe_defs.svh"

module tb;
	timeunit 1ns;
	timeprecision 1ns;

	// ------------------------------------------------------------------
	// Signals
	// ------------------------------------------------------------------
	logic        ref_clk, rst_n, avs_read, avs_write, avs_waitrequest;
	logic [3:0]  avs_address;
	logic [31:0] avs_writedata, avs_readdata, r;
	logic        xdm_wr, xdm_rd, cm_rd, core_stall, external_data_ram_we, external_data_ram_re;
	logic [15:0] xdm_addr, external_data_ram_addr;
	logic [7:0]  xdm_wdata, cm_rdata, external_data_ram_wdata, dbg_wdata, b;
	logic [9:0]  cm_addr, dbg_addr;
	logic        dbg_req, dbg_erase, vdd_mon_on, vdd_mon_rst_on;
	logic        flash_blank, flash_err_rst, irq;
	int          n_errors, tests_run;

	flpe_top #(.ERASE_CYC(20)) flpe_top_inst (.ref_clk, .rst_n,
		.avs_address, .avs_read, .avs_write, .avs_writedata,
		.avs_readdata, .avs_waitrequest, .xdm_wr, .xdm_rd, .xdm_addr,
		.xdm_wdata, .cm_rd, .cm_addr, .cm_rdata, .core_stall, .external_data_ram_we,
		.external_data_ram_re, .external_data_ram_addr, .external_data_ram_wdata, .dbg_req, .dbg_erase,
		.dbg_addr, .dbg_wdata, .vdd_mon_on, .vdd_mon_rst_on,
		.flash_blank, .flash_err_rst, .irq);

	flpe_core_model core_inst (.ref_clk, .core_stall, .cm_rdata, .xdm_wr,
		.xdm_rd, .xdm_addr, .xdm_wdata, .cm_rd, .cm_addr);

	// 10 MHz clock
	initial begin
		ref_clk = 1'b0;
		forever #50 ref_clk = ~ref_clk;
	end

	// ------------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------------
	task chk(input logic [31:0] g, input logic [31:0] e);
		tests_run++;
		if (g !== e) begin
			n_errors++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask : chk

	task do_rst;
		@(posedge ref_clk);
		rst_n <= 1'b0;
		repeat (3) @(posedge ref_clk);
		rst_n <= 1'b1;
		repeat (3) @(posedge ref_clk);
	endtask : do_rst

	// Avalon access held until waitrequest is seen low; result in r
	task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		avs_write <= w;
		avs_read <= !w;
		avs_address <= a;
		avs_writedata <= d;
		do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
		r = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
	endtask : bus

	task keys;
		bus(1'b1, 4'h4, {24'h0, `FLPE_KEY_FIRST});
		bus(1'b1, 4'h4, {24'h0, `FLPE_KEY_SECOND});
	endtask : keys

	task cmchk(input logic [9:0] a, input logic [7:0] e);
		core_inst.cread(a, b);
		chk(b, e);
	endtask : cmchk

	// Keyed flash operation, then wait out the stall
	task do_op(input logic [1:0] c, input logic [15:0] a, input logic [7:0] d);
		int n;
		bus(1'b1, 4'h0, {30'h0, c});
		keys;
		core_inst.mv(1'b1, a, d);
		@(negedge ref_clk);
		chk(core_stall, 1'b1);
		bus(1'b0, 4'h0, 32'h0);
		chk(r[`FLPE_CTRL_BUSY], 1'b1);
		// The busy read above spent three edges of the stall
		n = 3;
		while (core_stall !== 1'b0) begin
			@(posedge ref_clk);
			n++;
		end
		chk(n >= `FLPE_PROG_CYC, 1'b1);
		bus(1'b0, 4'h4, 32'h0);
		chk(r[1:0], 2'h0);
		bus(1'b0, 4'h0, 32'h0);
		chk(r[1:0], c);
		bus(1'b1, 4'h0, 32'h0);
	endtask : do_op

	// ------------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------------
	task t_ram;
		bus(1'b0, 4'h2, 32'h0);
		chk(r, 32'h0);
		core_inst.mv(1'b1, 16'h1234, 8'h3c);
		@(negedge ref_clk);
		chk({external_data_ram_we, external_data_ram_addr, external_data_ram_wdata}, {1'b1, 24'h12343c});
		bus(1'b0, 4'h4, 32'h0);
		chk(r[1:0], 2'h0);
		bus(1'b1, 4'h0, 32'h1);
		core_inst.mv(1'b0, 16'h0042, 8'h00);
		@(negedge ref_clk);
		chk({external_data_ram_re, external_data_ram_addr}, {1'b1, 16'h0042});
		$display("test ram done");
	endtask : t_ram

	task t_erase;
		do_op(2'h3, 16'h0005, 8'h00);
		cmchk(10'h1ff, `FLPE_ERASED);
		@(posedge ref_clk);
		dbg_req <= 1'b1;
		dbg_addr <= 10'h1fe;
		dbg_wdata <= 8'h11;
		@(posedge ref_clk);
		dbg_req <= 1'b0;
		repeat (`FLPE_PROG_CYC + 20) @(posedge ref_clk);
		cmchk(10'h1fe, 8'h11);
		do_op(2'h3, 16'h03ff, 8'h00);
		cmchk(10'h1fe, 8'h11);
		cmchk(10'h200, `FLPE_ERASED);
		cmchk(10'h3ff, `FLPE_ERASED);
		$display("test erase done");
	endtask : t_erase

	task t_prog;
		cmchk(10'h010, `FLPE_ERASED);
		do_op(2'h1, 16'h0010, 8'h5a);
		cmchk(10'h010, 8'h5a);
		cmchk(10'h011, `FLPE_ERASED);
		do_op(2'h1, 16'h0010, 8'hf0);
		cmchk(10'h010, 8'h50);
		$display("test program done");
	endtask : t_prog

	task t_irq;
		bus(1'b0, 4'h8, 32'h0);
		chk({irq, r[2:0]}, 4'h1);
		bus(1'b1, 4'hc, 32'h1);
		@(negedge ref_clk);
		chk(irq, 1'b1);
		bus(1'b1, 4'h8, 32'h1);
		repeat (2) @(posedge ref_clk);
		@(negedge ref_clk);
		chk(irq, 1'b0);
		bus(1'b0, 4'hc, 32'h0);
		chk(r[2:0], 3'h1);
		$display("test irq done");
	endtask : t_irq

	task t_vdd;
		@(posedge ref_clk);
		vdd_mon_rst_on <= 1'b0;
		repeat (3) @(posedge ref_clk);
		bus(1'b1, 4'h0, 32'h1);
		keys;
		core_inst.mv(1'b1, 16'h0011, 8'h00);
		@(negedge ref_clk);
		chk({flash_err_rst, core_stall}, 2'h2);
		@(posedge ref_clk);
		vdd_mon_rst_on <= 1'b1;
		cmchk(10'h011, `FLPE_ERASED);
		bus(1'b0, 4'h8, 32'h0);
		chk(r[2], 1'b1);
		// Blank array: firmware write dropped, key left open
		flash_blank <= 1'b1;
		repeat (3) @(posedge ref_clk);
		core_inst.mv(1'b1, 16'h0011, 8'h00);
		@(negedge ref_clk);
		chk(core_stall, 1'b0);
		bus(1'b0, 4'h4, 32'h0);
		chk(r[1:0], 2'h1);
		@(posedge ref_clk);
		flash_blank <= 1'b0;
		$display("test supply done");
	endtask : t_vdd

	// Wrong code, wrong order, attempt before keys
	task t_key;
		logic [7:0] k1 [3];
		logic [7:0] k2 [3];
		k1 = '{8'ha5, 8'hf1, 8'h00};
		k2 = '{8'h00, 8'ha5, 8'h00};
		for (int i = 0; i < 3; i++) begin
			do_rst;
			bus(1'b1, 4'h0, 32'h1);
			if (i < 2) begin
				bus(1'b1, 4'h4, {24'h0, k1[i]});
				bus(1'b1, 4'h4, {24'h0, k2[i]});
			end else begin
				core_inst.mv(1'b1, 16'h0012, 8'h00);
			end
			bus(1'b0, 4'h8, 32'h0);
			chk(r[1], 1'b1);
			keys;
			bus(1'b0, 4'h4, 32'h0);
			chk(r[1:0], 2'h2);
			core_inst.mv(1'b1, 16'h0012, 8'h00);
			@(negedge ref_clk);
			chk(core_stall, 1'b0);
			cmchk(10'h012, `FLPE_ERASED);
		end
		$display("test key done");
	endtask : t_key

	task final_report;
		$display("checks %0d mismatches %0d", tests_run, n_errors);
		if (n_errors == 0 && tests_run > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : final_report

	// Main sequence
	initial begin
		{rst_n, avs_read, avs_write, dbg_req, dbg_erase} = 5'h0;
		{avs_address, avs_writedata, dbg_addr, dbg_wdata} = '0;
		{vdd_mon_on, vdd_mon_rst_on, flash_blank} = 3'h6;
		n_errors = 0;
		tests_run = 0;
		do_rst;
		t_ram;
		t_erase;
		t_prog;
		t_irq;
		t_vdd;
		t_key;
		final_report;
	end

	// Watchdog, far beyond the few thousand cycles expected
	initial begin
		#3000000;
		n_errors++;
		final_report;
	end
endmodule : tb
